/* File: bench/host_bus_port_tb.sv */
`timescale 1ns/1ps
// ====================================================================
// Host port testbench
// ====================================================================
module host_bus_port_tb;
   import host_port_pkg::*;
   typedef struct packed {
      logic        st;
      logic [2:0]  a;
      logic [15:0] e;
   } row_s;
   logic        mclk;
   logic        arst_n;
   host_in_s    h;
   host_in_s    host_in;
   logic [15:0] host_data_out;
   logic        host_data_oe_n;
   logic        new_data_irq;
   cfg_wr_s     cfg_wr;
   cfg_wr_s     last_wr;
   logic [15:0] cfg_rd_addr;
   logic [15:0] d;
   logic        oe_n;
   logic [3:0]  chan_synced;
   logic [3:0]  chan_new;
   int          fails = 0;
   int          tests_run = 0;
   int          irq_cnt = 0;
   int          wr_cnt = 0;
   row_s        rows[6];

   // Clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Wire level of the shared data bus
   always_comb begin
      host_in = h;
      if (!host_data_oe_n) host_in.data = host_data_out;
   end

   // Count target write pulses and interrupt cycles
   always @(posedge mclk) begin
      if (cfg_wr.valid) begin
         wr_cnt++;
         last_wr = cfg_wr;
      end
      if (new_data_irq) irq_cnt++;
   end

   host_model host_model_i (.mclk(mclk), .bus(host_in.data), .bus_oe_n(host_data_oe_n),
                            .h(h));
   host_bus_port host_bus_port_i (.mclk(mclk), .arst_n(arst_n), .host_in(host_in),
      .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
      .new_data_irq(new_data_irq), .cfg_wr(cfg_wr), .cfg_rd_addr(cfg_rd_addr),
      .cfg_rd_data(~cfg_rd_addr), .chan_data(64'hd3d3_c2c2_b1b1_a0a0),
      .chan_synced(chan_synced), .chan_new(chan_new));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic summarize();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog
   initial begin
      #20000;
      fails++;
      summarize();
   end

   // Main sequence
   initial begin
      arst_n = 1'b0;
      chan_synced = 4'b0101;
      chan_new = 4'h0;
      rows = '{'{1'b0, 3'h0, 16'h0a02}, '{1'b1, 3'h0, 16'h0a02}, '{1'b0, 3'h4, 16'h0a02},
               '{1'b1, 3'h1, 16'h0005}, '{1'b0, 3'h2, 16'hc2c2}, '{1'b1, 3'h3, 16'hf5fd}};
      repeat (6) @(negedge mclk);
      arst_n = 1'b1;
      chk("reset oe_n", 16'h1, host_data_oe_n);
      host_model_i.wr(1'b0, 1'b0, 3'h0, 16'h0a02);
      foreach (rows[i]) begin
         host_model_i.rd(rows[i].st, rows[i].a, d, oe_n);
         chk("read data", rows[i].e, d);
         chk("read oe_n", 16'h0, oe_n);
         repeat (2) @(negedge mclk);
         chk("idle oe_n", 16'h1, host_data_oe_n);
      end
      // Deselected write is ignored
      host_model_i.wr(1'b0, 1'b1, 3'h0, 16'h1111);
      host_model_i.rd(1'b0, 3'h0, d, oe_n);
      chk("deselected write", 16'h0a02, d);
      // Unsynchronized channel reads zero
      host_model_i.wr(1'b1, 1'b0, 3'h0, 16'h0301);
      host_model_i.rd(1'b0, 3'h2, d, oe_n);
      chk("unsynced chan", 16'h0000, d);
      // Target write in style high sets interrupt channel 1, length 3
      host_model_i.wr(1'b1, 1'b0, 3'h1, IRQ_CFG_ADDR);
      @(negedge mclk); // Pulse is counted at the edge after it rises
      chk("target pulses", 16'h1, 16'(wr_cnt));
      chk("target addr", IRQ_CFG_ADDR, last_wr.addr);
      chk("target data", 16'h0301, last_wr.data);
      // Unselected then selected channel events
      for (int k = 2; k > 0; k--) begin
         @(negedge mclk);
         chan_new = 4'h1 << k;
         @(negedge mclk);
         chan_new = 4'h0;
         repeat (8) @(negedge mclk);
         chk("irq cycles", k == 2 ? 16'h0 : 16'h3, 16'(irq_cnt));
      end
      // Reset in mid-run clears holding and releases the bus
      arst_n = 1'b0;
      @(negedge mclk);
      chk("mid reset oe_n", 16'h1, host_data_oe_n);
      arst_n = 1'b1;
      host_model_i.rd(1'b0, 3'h0, d, oe_n);
      chk("holding reset", HOLD_RST, d);
      // Interrupt setup back to channel 0, one cycle
      chan_new = 4'h1;
      @(negedge mclk);
      chan_new = 4'h0;
      repeat (4) @(negedge mclk);
      chk("irq reset len", 16'h4, 16'(irq_cnt));
      summarize();
   end
endmodule // host_bus_port_tb

/* File: bench/host_model.sv */
`timescale 1ns/1ps
// ====================================================================
// Host processor model for the parallel port
// ====================================================================
module host_model
   import host_port_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic [15:0] bus,
   input  wire logic        bus_oe_n,
   output host_in_s         h
);
   // Idle: deselected, strobes high
   initial h = '{1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 16'h0000};

   // Write: select and address stay put across the strobe
   task automatic wr(input logic st, input logic cs_n, input logic [2:0] a,
                     input logic [15:0] d);
      @(negedge mclk);
      h.bus_style = st;
      h.chip_sel_n = cs_n;
      h.addr = a;
      h.data = d;
      h.read_strobe_n = ~st; // Direction low in style high
      h.write_strobe_n = 1'b0;
      @(negedge mclk);
      h.write_strobe_n = 1'b1; // Rising strobe moves the word
      @(negedge mclk);
      h.chip_sel_n = 1'b1;
      h.read_strobe_n = 1'b1;
      h.data = ~h.data; // Released bus shows no stale value
   endtask

   // Read: hold the access three cycles, take the bus, release
   task automatic rd(input logic st, input logic [2:0] a, output logic [15:0] d,
                     output logic oe_n);
      @(negedge mclk);
      h.bus_style = st;
      h.chip_sel_n = 1'b0;
      h.addr = a;
      h.read_strobe_n = st;
      h.write_strobe_n = ~st;
      repeat (3) @(negedge mclk);
      d = bus;
      oe_n = bus_oe_n;
      h.read_strobe_n = 1'b1;
      h.write_strobe_n = 1'b1; // Strobe ends while still selected
      @(negedge mclk);
      h.chip_sel_n = 1'b1;
   endtask
endmodule // host_model

/* File: logic/host_bus_port.sv */
`timescale 1ns/1ps
// =============================================================================
// Summary of operation
// - Sixteen-bit two-way host data bus, bit 15 is the most significant.
// - Three address lines accepted, only the lower two are decoded.
// - Style low: write strobe rising edge with chip select low transfers.
// - Style high, direction low: data strobe rising edge performs the write.
// - Style high, direction high: addressed data driven while data strobe low.
// - Style low: addressed data driven while read strobe and chip select low.
// - Static style pin picks strobe scheme; pulled low by default.
// - New data on selected channel raises interrupt for programmed cycle count.
// - Channel output data readable only for synchronized channels.
// =============================================================================
module host_bus_port
   import host_port_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int DATA_W = 16,
   parameter int LEN_W  = 8
) (
   input  wire logic                         mclk,
   input  wire logic                         arst_n,
   input  wire host_in_s                     host_in,
   output logic [DATA_W-1:0]                 host_data_out,
   output logic                              host_data_oe_n,
   output logic                              new_data_irq,
   output cfg_wr_s                           cfg_wr,
   output logic [15:0]                       cfg_rd_addr,
   input  wire logic [15:0]                  cfg_rd_data,
   input  wire logic [NUM_CH*DATA_W-1:0]     chan_data,
   input  wire logic [NUM_CH-1:0]            chan_synced,
   input  wire logic [NUM_CH-1:0]            chan_new
);

   localparam int SEL_W = $clog2(NUM_CH);

   // =========================================================================
   // Strobe decode
   // =========================================================================
   logic              wr_strobe_q;
   logic              write_edge;
   logic              read_active;
   logic [1:0]        reg_sel;
   logic [15:0]       holding;
   logic [SEL_W-1:0]  irq_sel;
   logic [LEN_W-1:0]  irq_len;
   logic [DATA_W-1:0] next_rdata;
   logic [SEL_W-1:0]  rd_chan;

   // Delayed strobe for rising-edge detection
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_strobe_q <= 1'b1;
      end else begin
         wr_strobe_q <= host_in.write_strobe_n;
      end
   end

   // Style pin selects which line qualifies the write edge
   always_comb begin
      write_edge = !wr_strobe_q && host_in.write_strobe_n && !host_in.chip_sel_n;
      if (host_in.bus_style) begin
         write_edge = write_edge && !host_in.read_strobe_n;
      end
   end

   // Read window per style
   always_comb begin
      if (host_in.bus_style) begin
         read_active = !host_in.write_strobe_n && host_in.read_strobe_n
                       && !host_in.chip_sel_n;
      end else begin
         read_active = !host_in.read_strobe_n && !host_in.chip_sel_n;
      end
   end

   // Top address line ignored
   assign reg_sel = host_in.addr[1:0];

   // =========================================================================
   // Write path
   // =========================================================================

   // Holding register load from the bus
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         holding <= HOLD_RST;
      end else if (write_edge && reg_sel == ADDR_HOLD) begin
         holding <= host_in.data;
      end
   end

   // Holding register moved to target named on the bus
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_wr <= '0;
      end else begin
         cfg_wr.valid <= write_edge && reg_sel == ADDR_TARGET;
         cfg_wr.addr  <= host_in.data;
         cfg_wr.data  <= holding;
      end
   end

   // Interrupt setup caught from target writes
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_sel <= SEL_W'(IRQ_SEL_RST);
         irq_len <= LEN_W'(IRQ_LEN_RST);
      end else if (write_edge && reg_sel == ADDR_TARGET && host_in.data == IRQ_CFG_ADDR) begin
         irq_sel <= holding[IRQ_SEL_LSB +: SEL_W];
         irq_len <= holding[IRQ_LEN_LSB +: LEN_W];
      end
   end

   // =========================================================================
   // Read path
   // =========================================================================

   // Channel picked by holding register low bits
   assign rd_chan = holding[SEL_W-1:0];

   // Core readback address follows holding register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_rd_addr <= HOLD_RST;
      end else begin
         cfg_rd_addr <= holding;
      end
   end

   // Read data mux
   always_comb begin
      case (reg_sel)
         ADDR_HOLD:   next_rdata = holding;
         ADDR_TARGET: next_rdata = DATA_W'(chan_synced);
         ADDR_CHAN: begin
            if (chan_synced[rd_chan]) begin
               next_rdata = chan_data[rd_chan*DATA_W +: DATA_W];
            end else begin
               next_rdata = '0;
            end
         end
         ADDR_CFG_RD: next_rdata = cfg_rd_data;
         default:     next_rdata = '0;
      endcase
   end

   // Registered bus drive, released outside reads
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         host_data_out  <= '0;
         host_data_oe_n <= 1'b1;
      end else begin
         host_data_out  <= read_active ? next_rdata : '0;
         host_data_oe_n <= !read_active;
      end
   end

   // =========================================================================
   // Interrupt
   // =========================================================================
   irq_pulse #(
      .NUM_CH (NUM_CH),
      .LEN_W  (LEN_W)
   ) u_irq (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .chan_new (chan_new),
      .irq_sel  (irq_sel),
      .irq_len  (irq_len),
      .irq      (new_data_irq)
   );

   // =========================================================================
   // Checks
   // =========================================================================
   drive_only_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !host_data_oe_n |-> $past(read_active))
      else $error("bus driven outside a read");

   read_drives_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !host_in.bus_style && !host_in.read_strobe_n && !host_in.chip_sel_n
      |=> !host_data_oe_n)
      else $error("separate-strobe read not driven");

   ds_read_drives_a: assert property (@(posedge mclk) disable iff (!arst_n)
      host_in.bus_style && host_in.read_strobe_n && !host_in.write_strobe_n
      && !host_in.chip_sel_n |=> !host_data_oe_n ##0 host_data_out == $past(next_rdata))
      else $error("data-strobe read not driven");

   hold_load_a: assert property (@(posedge mclk) disable iff (!arst_n)
      write_edge && host_in.addr[1:0] == ADDR_HOLD |=> holding == $past(host_in.data))
      else $error("holding register not loaded");

   target_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      write_edge && reg_sel == ADDR_TARGET
      |=> cfg_wr.valid && cfg_wr.data == $past(holding) && cfg_wr.addr == $past(host_in.data))
      else $error("target transfer missing");

   no_write_on_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
      host_in.bus_style && host_in.read_strobe_n |=> !cfg_wr.valid)
      else $error("write taken while direction line reads");

   unsync_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
      read_active && reg_sel == ADDR_CHAN && !chan_synced[rd_chan] |=> host_data_out == '0)
      else $error("unsynchronized channel data exposed");

   idle_released_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !read_active |=> host_data_oe_n && host_data_out == '0)
      else $error("bus not released after read");

   desel_no_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      host_in.chip_sel_n |=> !cfg_wr.valid && holding == $past(holding))
      else $error("write taken while deselected");

   dir_read_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
      host_in.bus_style && host_in.read_strobe_n |=> holding == $past(holding))
      else $error("holding loaded while direction line reads");

   irq_setup_a: assert property (@(posedge mclk) disable iff (!arst_n)
      write_edge && reg_sel == ADDR_TARGET && host_in.data == IRQ_CFG_ADDR
      |=> irq_len == cfg_wr.data[IRQ_LEN_LSB +: LEN_W]
      && irq_sel == cfg_wr.data[IRQ_SEL_LSB +: SEL_W])
      else $error("interrupt setup not taken from holding");

endmodule // host_bus_port

/* File: logic/host_port_pkg.sv */
// =============================================================================
// Shared constants and carriers
// =============================================================================
package host_port_pkg;

   // Host address map (low two address lines)
   localparam logic [1:0]  ADDR_HOLD     = 2'h0; // Write: load holding; read: holding
   localparam logic [1:0]  ADDR_TARGET   = 2'h1; // Write: holding to target; read: sync flags
   localparam logic [1:0]  ADDR_CHAN     = 2'h2; // Read: channel output data
   localparam logic [1:0]  ADDR_CFG_RD   = 2'h3; // Read: core config readback

   // Interrupt setup target address and field layout
   localparam logic [15:0] IRQ_CFG_ADDR  = 16'h0010;
   localparam int          IRQ_SEL_LSB   = 0;
   localparam int          IRQ_LEN_LSB   = 8;

   // Reset values
   localparam logic [15:0] HOLD_RST      = 16'h0000;
   localparam logic [7:0]  IRQ_LEN_RST   = 8'h01;
   localparam logic [1:0]  IRQ_SEL_RST   = 2'h0;

   // Host bus pins as sampled on mclk
   typedef struct packed {
      logic        chip_sel_n;
      logic        write_strobe_n;  // Doubles as data_strobe_n in style high
      logic        read_strobe_n;   // Doubles as read/write line in style high
      logic        bus_style;       // Low: separate strobes, high: strobe plus direction
      logic [2:0]  addr;
      logic [15:0] data;
   } host_in_s;

   // Write into the core's target register space
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [15:0] data;
   } cfg_wr_s;

endpackage

/* File: logic/irq_pulse.sv */
`timescale 1ns/1ps
// =============================================================================
// New-data interrupt pulse stretcher
// =============================================================================
module irq_pulse
   import host_port_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int LEN_W  = 8
) (
   input  wire logic                      mclk,
   input  wire logic                      arst_n,
   input  wire logic [NUM_CH-1:0]         chan_new,
   input  wire logic [$clog2(NUM_CH)-1:0] irq_sel,
   input  wire logic [LEN_W-1:0]          irq_len,
   output logic                           irq
);

   logic [LEN_W-1:0] cnt;
   logic             event_hit;

   // Event on the selected channel only
   assign event_hit = chan_new[irq_sel];

   // Pulse of irq_len cycles, zero length stretched to one
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= '0;
         irq <= 1'b0;
      end else if (event_hit) begin
         cnt <= (irq_len == '0) ? LEN_W'(1) : irq_len;
         irq <= 1'b1;
      end else if (cnt > LEN_W'(1)) begin
         cnt <= cnt - LEN_W'(1);
      end else begin
         cnt <= '0;
         irq <= 1'b0;
      end
   end

   irq_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
      event_hit && irq_len != '0 |=> irq && cnt == $past(irq_len))
      else $error("irq did not start with programmed length");

   irq_end_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(irq) |-> $past(cnt) == LEN_W'(1) && !$past(event_hit))
      else $error("irq ended before its count ran out");

endmodule // irq_pulse
